// ===== test/tb.sv
/*
 * self-checking bench for bit_toggle_xor_exec: invert, xor immediate, xor memory.
 * assumes a combinational data memory held here and one start per instruction cycle.
 */
`timescale 1ns/1ps
module tb;
  import bitxor_pkg::*;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] working_register;
    logic       z;
  } res_t;

  logic        clk      = 1'b0;
  logic        rst      = 1'b1;
  logic        q1_start = 1'b0;
  logic [15:0] instr    = 16'h0000;
  mem_req_t    mem_q;
  logic [7:0]  mem_rdata;
  logic [7:0]  working_register_q;
  logic        zero_flag_q;
  logic        busy_q;
  logic [7:0]  mem [256];
  logic [7:0]  ref_mem [256];
  logic [7:0]  ref_w;
  logic        ref_z;
  res_t        exp_q [$];
  res_t        cap      = '0;
  logic        busy_d   = 1'b0;
  int          errors      = 0;
  int          check_count = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, dut and data memory
  always #4 clk = ~clk;

  bit_toggle_xor_exec u_dut (
    .clk(clk), .rst(rst), .q1_start(q1_start), .instr(instr), .mem_q(mem_q),
    .mem_rdata(mem_rdata), .working_register_q(working_register_q),
    .zero_flag_q(zero_flag_q), .busy_q(busy_q));

  assign mem_rdata = mem[mem_q.addr];

  // memory takes the write pulse
  always @(posedge clk) if (mem_q.wr === 1'b1) mem[mem_q.addr] <= mem_q.wdata;

  ////////////////////////////////////////////////////////////////////////////
  // compare tasks and closing report
  task automatic check_res(input res_t got, input res_t exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_res

  // cycle and bookkeeping counts
  task automatic check_num(input int got, input int exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_num

  task automatic stop_test;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // monitor: grab write pulse, compare when busy falls
  always @(negedge clk) begin
    if (mem_q.rd === 1'b1) cap.rd = 1'b1;
    if (mem_q.wr === 1'b1) begin
      cap.wr    = 1'b1;
      cap.addr  = mem_q.addr;
      cap.wdata = mem_q.wdata;
    end
    if (busy_d === 1'b1 && busy_q === 1'b0) begin
      cap.working_register = working_register_q;
      cap.z    = zero_flag_q;
      if (exp_q.size() == 0) check_res(cap, '1);
      else check_res(cap, exp_q.pop_front());
      cap = '0;
    end
    busy_d = busy_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // issue one instruction and note its expected result
  task automatic run(input logic [15:0] i);
    res_t       e;
    logic [7:0] f;
    logic [7:0] r;
    int         n;
    e = '0;
    f = i[7:0];
    n = 0;
    casez (i[15:8])
      8'b0011_1???: begin
        e.rd = 1'b1;
        e.wr = 1'b1; e.addr = f; e.wdata = ref_mem[f] ^ (8'h01 << i[10:8]);
        ref_mem[f] = e.wdata;
      end
      8'hb4: begin
        r = ref_w ^ f; ref_w = r; ref_z = (r == 8'h00);
      end
      8'b0000_110?: begin
        e.rd = 1'b1;
        r = ref_w ^ ref_mem[f]; ref_z = (r == 8'h00);
        if (i[8]) begin e.wr = 1'b1; e.addr = f; e.wdata = r; ref_mem[f] = r; end
        else ref_w = r;
      end
      default: ;
    endcase
    e.working_register = ref_w;
    e.z    = ref_z;
    exp_q.push_back(e);
    @(posedge clk);
    q1_start <= 1'b1;
    instr    <= i;
    @(posedge clk);
    // a start seen while busy must be ignored
    q1_start <= 1'($urandom);
    instr    <= 16'($urandom);
    @(negedge clk);
    if (busy_q === 1'b1) n++;
    @(posedge clk);
    q1_start <= 1'b0;
    for (int k = 0; k < 12; k++) begin
      @(negedge clk);
      if (busy_q !== 1'b1) break;
      n++;
    end
    check_num(n, BUSY_PHASES);
    if (busy_q !== 1'b0) begin
      errors++;
      $display("ERROR t=%0t busy stuck got=%h exp=%h", $time, busy_q, 1'b0);
      stop_test();
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'hab00a004));
    for (int a = 0; a < 256; a++) begin mem[a] = 8'($urandom); ref_mem[a] = mem[a]; end
    ref_w = WORKING_REGISTER_RESET;
    ref_z = ZERO_RESET;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int b = 0; b < 8; b++) run({BIT_INVERT_TOP, 3'(b), (b[0] ? 8'hff : 8'h00)});
    $display("test bit invert done");
    run({XOR_IMM_TOP, 8'h5a});
    run({XOR_IMM_TOP, 8'h5a});
    run({XOR_IMM_TOP, 8'hff});
    $display("test xor immediate done");
    for (int d = 0; d < 2; d++) begin
      run({XOR_MEM_TOP, 1'(d), 8'h00});
      run({XOR_MEM_TOP, 1'(d), 8'hff});
    end
    run({XOR_IMM_TOP, ref_w ^ ref_mem[8'h10]});
    run({XOR_MEM_TOP, 1'b0, 8'h10});
    run(16'hffff);
    $display("test xor memory done");
    for (int k = 0; k < 40; k++) begin
      case ($urandom_range(2))
        0: run({BIT_INVERT_TOP, 3'($urandom), 8'($urandom)});
        1: run({XOR_IMM_TOP, 8'($urandom)});
        default: run({XOR_MEM_TOP, 1'($urandom), 8'($urandom)});
      endcase
    end
    $display("test random mix done");
    // let the last result reach the monitor before closing
    @(posedge clk);
    check_num(exp_q.size(), 0);
    stop_test();
  end
endmodule : tb

// ===== verilog/bit_toggle_xor_exec.sv
/*
 * executes bit invert, xor immediate and xor memory over four phases.
 * assumes the core supplies phase q1 pulses and a one-phase memory read.
 */
// Function
// - bit invert flips one bit, flags untouched
// - four phases: decode, read, execute, write
// - xor immediate result goes to working register
// - xor memory, d=0: result to working register
// - xor memory, d=1: result to memory
`timescale 1ns/1ps
module bit_toggle_xor_exec
  import bitxor_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // instruction cycle
  input  wire logic        q1_start,
  input  wire logic [15:0] instr,
  // data memory
  output mem_req_t         mem_q,
  input  wire logic [7:0]  mem_rdata,
  // core state
  output logic [7:0]       working_register_q,
  output logic             zero_flag_q,
  output logic             busy_q
);

  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_EXEC, PH_WRITE} phase_t;

  phase_t      phase_q;
  decoded_t    dec_w;
  decoded_t    dec_q;
  logic [7:0]  opnd_q;
  logic [7:0]  result_q;

  bitxor_decode u_dec (
    .instr (instr),
    .dec   (dec_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // phase sequencer, one step per clock while busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_DECODE;
      busy_q  <= 1'b0;
    end else if (!busy_q) begin
      if (q1_start) begin
        busy_q  <= 1'b1;
        phase_q <= PH_READ;
      end
    end else begin
      unique case (phase_q)
        PH_DECODE: phase_q <= PH_READ;
        PH_READ:   phase_q <= PH_EXEC;
        PH_EXEC:   phase_q <= PH_WRITE;
        PH_WRITE: begin
          phase_q <= PH_DECODE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // latch decoded instruction in decode phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_q <= '0;
    end else if (!busy_q && q1_start) begin
      dec_q <= dec_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operand read and execute
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opnd_q   <= 8'h00;
      result_q <= 8'h00;
    end else if (busy_q && phase_q == PH_READ) begin
      opnd_q <= (dec_q.op == OP_XOR_IMM) ? dec_q.literal : mem_rdata;
    end else if (busy_q && phase_q == PH_EXEC) begin
      if (dec_q.op == OP_BIT_INVERT) begin
        result_q <= opnd_q ^ (8'h01 << dec_q.bit_idx);
      end else begin
        result_q <= working_register_q ^ opnd_q;
      end
    end
  end

  // memory request: read during read phase, write during write phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_q <= '0;
    end else begin
      mem_q.addr  <= busy_q ? dec_q.addr : dec_w.addr;
      mem_q.rd    <= !busy_q && q1_start
                     && (dec_w.op == OP_BIT_INVERT || dec_w.op == OP_XOR_MEM);
      mem_q.wr    <= busy_q && phase_q == PH_EXEC
                     && (dec_q.op == OP_BIT_INVERT
                         || (dec_q.op == OP_XOR_MEM && dec_q.dest_mem));
      mem_q.wdata <= (dec_q.op == OP_BIT_INVERT)
                     ? opnd_q ^ (8'h01 << dec_q.bit_idx)
                     : working_register_q ^ opnd_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // working register and zero flag, written in write phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      working_register_q <= WORKING_REGISTER_RESET;
      zero_flag_q        <= ZERO_RESET;
    end else if (busy_q && phase_q == PH_WRITE) begin
      if (dec_q.op == OP_XOR_IMM
          || (dec_q.op == OP_XOR_MEM && !dec_q.dest_mem)) begin
        working_register_q <= result_q;
      end
      if (dec_q.op == OP_XOR_IMM || dec_q.op == OP_XOR_MEM) begin
        zero_flag_q <= (result_q == 8'h00);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_four_phase;
    @(posedge clk) disable iff (rst)
    (!busy_q && q1_start) |=> busy_q [*3] ##1 !busy_q;
  endproperty
  a_four_phase: assert property (p_four_phase) else $error("cycle not four phases");

  property p_imm_result;
    @(posedge clk) disable iff (rst)
    (!busy_q && q1_start && dec_w.op == OP_XOR_IMM)
      |=> ##3 working_register_q == ($past(working_register_q, 1) ^ $past(instr[7:0], 4));
  endproperty
  a_imm_result: assert property (p_imm_result) else $error("xor immediate wrong");

  property p_mem_d0_nowrite;
    @(posedge clk) disable iff (rst)
    (busy_q && phase_q == PH_EXEC && dec_q.op == OP_XOR_MEM && !dec_q.dest_mem)
      |=> !mem_q.wr;
  endproperty
  a_mem_d0_nowrite: assert property (p_mem_d0_nowrite) else $error("d=0 wrote memory");

  property p_mem_d1_working_register;
    @(posedge clk) disable iff (rst)
    (busy_q && phase_q == PH_READ && dec_q.op == OP_XOR_MEM && dec_q.dest_mem)
      |=> ##2 $stable(working_register_q) && $past(mem_q.wr);
  endproperty
  a_mem_d1_working_register: assert property (p_mem_d1_working_register) else $error("d=1 handling wrong");

  property p_invert_one_bit;
    @(posedge clk) disable iff (rst)
    (mem_q.wr && dec_q.op == OP_BIT_INVERT)
      |-> $countones(mem_q.wdata ^ opnd_q) == 1;
  endproperty
  a_invert_one_bit: assert property (p_invert_one_bit) else $error("invert not one bit");

  property p_invert_flags;
    @(posedge clk) disable iff (rst)
    (busy_q && phase_q == PH_WRITE && dec_q.op == OP_BIT_INVERT)
      |=> $stable(zero_flag_q) && $stable(working_register_q);
  endproperty
  a_invert_flags: assert property (p_invert_flags) else $error("invert touched state");

  property p_zero_flag;
    @(posedge clk) disable iff (rst)
    (busy_q && phase_q == PH_WRITE && dec_q.op inside {OP_XOR_IMM, OP_XOR_MEM})
      |=> zero_flag_q == ($past(result_q) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_read_first;
    @(posedge clk) disable iff (rst)
    (!busy_q && q1_start && dec_w.op == OP_XOR_MEM) |=> mem_q.rd ##1 !mem_q.rd;
  endproperty
  a_read_first: assert property (p_read_first) else $error("read not in read phase");

  // phase placement, refusal of late starts and per-op data checks
  property p_start_ignored;
    @(posedge clk) disable iff (rst)
    (busy_q && q1_start) |=> $stable(dec_q);
  endproperty
  a_start_ignored: assert property (p_start_ignored) else $error("start taken while busy");

  property p_rd_in_read;
    @(posedge clk) disable iff (rst)
    mem_q.rd |-> busy_q && phase_q == PH_READ;
  endproperty
  a_rd_in_read: assert property (p_rd_in_read) else $error("read outside read phase");

  property p_wr_in_write;
    @(posedge clk) disable iff (rst)
    mem_q.wr |-> busy_q && phase_q == PH_WRITE;
  endproperty
  a_wr_in_write: assert property (p_wr_in_write) else $error("write outside write phase");

  property p_invert_target;
    @(posedge clk) disable iff (rst)
    (busy_q && phase_q == PH_EXEC && dec_q.op == OP_BIT_INVERT)
      |=> mem_q.wr && mem_q.addr == $past(dec_q.addr);
  endproperty
  a_invert_target: assert property (p_invert_target) else $error("invert wrote wrong place");

  property p_imm_no_mem;
    @(posedge clk) disable iff (rst)
    (busy_q && dec_q.op == OP_XOR_IMM) |-> !mem_q.rd && !mem_q.wr;
  endproperty
  a_imm_no_mem: assert property (p_imm_no_mem) else $error("xor immediate touched memory");

  property p_mem_d0_working_register;
    @(posedge clk) disable iff (rst)
    (busy_q && phase_q == PH_WRITE && dec_q.op == OP_XOR_MEM && !dec_q.dest_mem)
      |=> working_register_q == ($past(working_register_q) ^ $past(opnd_q));
  endproperty
  a_mem_d0_working_register: assert property (p_mem_d0_working_register) else $error("d=0 result wrong");

  property p_mem_d1_data;
    @(posedge clk) disable iff (rst)
    (busy_q && phase_q == PH_WRITE && dec_q.op == OP_XOR_MEM && dec_q.dest_mem)
      |-> mem_q.wr && mem_q.wdata == (working_register_q ^ opnd_q);
  endproperty
  a_mem_d1_data: assert property (p_mem_d1_data) else $error("d=1 write data wrong");

  property p_unknown_quiet;
    @(posedge clk) disable iff (rst)
    (busy_q && phase_q == PH_WRITE && dec_q.op == OP_NONE)
      |=> $stable(working_register_q) && $stable(zero_flag_q);
  endproperty
  a_unknown_quiet: assert property (p_unknown_quiet) else $error("unknown op changed state");

endmodule : bit_toggle_xor_exec

// ===== verilog/bitxor_decode.sv
/*
 * opcode decoder for the bit-invert and xor instructions.
 * assumes a stable instruction word during decode; purely combinational.
 */
`timescale 1ns/1ps
module bitxor_decode
  import bitxor_pkg::*;
(
  // instruction in
  input  wire logic [15:0] instr,
  // decoded out
  output decoded_t         dec
);

  // classify opcode and pull fields
  always_comb begin
    dec          = '0;
    dec.bit_idx  = instr[BIT_IDX_LSB +: 3];
    dec.dest_mem = instr[DEST_BIT_POS];
    dec.addr     = instr[7:0];
    dec.literal  = instr[7:0];
    if (instr[15:11] == BIT_INVERT_TOP) begin
      dec.op = OP_BIT_INVERT;
    end else if (instr[15:8] == XOR_IMM_TOP) begin
      dec.op = OP_XOR_IMM;
    end else if (instr[15:9] == XOR_MEM_TOP) begin
      dec.op = OP_XOR_MEM;
    end else begin
      dec.op = OP_NONE;
    end
  end

endmodule : bitxor_decode

// ===== verilog/bitxor_pkg.sv
/*
 * constants and carrier types for the bit-invert / xor instruction block.
 * assumes a 16-bit instruction word and 8-bit data memory with 256 locations.
 */
package bitxor_pkg;

  // opcode patterns
  localparam logic [4:0]  BIT_INVERT_TOP  = 5'h07;  // 0011 1
  localparam logic [7:0]  XOR_IMM_TOP     = 8'hb4;  // 1011 0100
  localparam logic [6:0]  XOR_MEM_TOP     = 7'h06;  // 0000 110
  // field positions
  localparam int          BIT_IDX_LSB     = 8;
  localparam int          DEST_BIT_POS    = 8;
  // reset values
  localparam logic [7:0]  WORKING_REGISTER_RESET      = 8'h00;
  localparam logic        ZERO_RESET      = 1'b0;
  // timing counts
  localparam int          BUSY_PHASES     = 3;  // read, execute, write after decode

  // instruction classes
  typedef enum logic [1:0] {
    OP_NONE,
    OP_BIT_INVERT,
    OP_XOR_IMM,
    OP_XOR_MEM
  } op_class_t;

  // decoded instruction
  typedef struct packed {
    op_class_t  op;
    logic [2:0] bit_idx;
    logic       dest_mem;
    logic [7:0] addr;
    logic [7:0] literal;
  } decoded_t;

  // data memory access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

endpackage : bitxor_pkg
